// ---- ext_bus_sdram_config_regs.vh ----
// Register map, field positions, reset values and command codes
`ifndef EXT_BUS_SDRAM_CONFIG_REGS_VH
`define EXT_BUS_SDRAM_CONFIG_REGS_VH
`define IDX_CTRL 4'h0
`define IDX_GEOM 4'h1
`define IDX_REF_LO 4'h4
`define IDX_REF_HI 4'h5
`define IDX_INIT_LO 4'h6
`define IDX_INIT_HI 4'h7
`define IDX_TIMING 4'h8
`define REG_RESET 8'h00
`define REF_HI_MASK 8'h03
`define INIT_HI_MASK 8'h3f
`define GEOM_MASK 8'h0f
`define FLD_PORT_COUNT 1:0
`define FLD_STATIC_MUX 3:2
`define FLD_LOW_PIN_MUX 5:4
`define FLD_BUS_WIDTH 7:6
`define FLD_COL_LATENCY 3
`define FLD_ROW_WIDTH 2
`define FLD_COL_WIDTH 1:0
`define FLD_REF_HI 1:0
`define FLD_INIT_HI 5:0
`define FLD_MODE_WAIT 7:6
`define FLD_REF_WAIT 5:3
`define FLD_ACT_WAIT 2:0
`define PORTS_OFF 2'h0
`define PORTS_THREE 2'h1
`define PORTS_FOUR 2'h2
`define PORTS_TWO 2'h3
`define WIDTH_FOUR 2'h0
`define WIDTH_EIGHT 2'h1
`define LOW_PIN_FIRST 2'h0
`define LOW_PIN_BOTH 2'h2
`define SRAM_FIRST 2'h0
`define SRAM_SECOND 2'h1
`define SRAM_BOTH 2'h2
`define SRAM_NONE 2'h3
`define CAS_SHORT 2'h2
`define CAS_LONG 2'h3
`define ROW_SHORT 4'hb
`define ROW_LONG 4'hc
`define COL_BASE 4'h8
`define REFRESH_QUEUE_MAX 3'h4
`define CMD_NOP 3'h0
`define CMD_PRECHARGE 3'h1
`define CMD_REFRESH 3'h2
`define CMD_LOAD_MODE 3'h3
`define CMD_ACTIVE 3'h4
`endif

// ---- ext_bus_sdram_config.v ----
// External bus configuration registers and SDRAM init/refresh/command sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ext_bus_sdram_config_regs.vh"

// Summary of operation
// R1 - Width code 00 four bits, 01 eight
// R2 - Eight-bit width only with four ports
// R3 - Low-pin mux: 00 first, 10 both strobes
// R4 - SRAM mux codes select latch scheme
// R5 - Second-latch and unmultiplexed need four ports
// R6 - Port count: off, three, four, two
// R7 - Column latency two or three cycles
// R8 - Row width eleven or twelve bits
// R9 - Column width eight to eleven bits
// R10 - Ten-bit refresh period in ticks
// R11 - Queue up to four pending refreshes
// R12 - Fourteen-bit power-up wait before init
// R13 - Init: precharge, refresh, load mode
// R14 - Load mode to active wait 0-3
// R15 - Refresh to active wait 0-7
// R16 - Active to precharge wait 0-7
// R17 - Enabled bus overrides data and address pins
// R18 - Reserved bits zero; reserved codes ignored
module ext_bus_sdram_config #(
  parameter [2:0] REFRESH_QUEUE_DEPTH = `REFRESH_QUEUE_MAX
) (
  input wire core_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  input wire fast_peripheral_clock,
  input wire ext_busy,
  input wire act_req,
  output wire act_ack,
  output reg [2:0] sdram_cmd,
  output reg sdram_ready,
  output reg [3:0] port_enable,
  output reg data_dir_override,
  output reg data_val_override,
  output reg addr_val_override,
  output reg data_width_eight,
  output reg [1:0] low_pin_mux_mode,
  output reg [1:0] static_ram_mux_mode,
  output reg [1:0] cas_latency,
  output reg [3:0] row_bits,
  output reg [3:0] col_bits,
  output reg [2:0] refresh_pending
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [3:0] ST_OFF = 4'h0;
  localparam [3:0] ST_PWR = 4'h1;
  localparam [3:0] ST_PRE = 4'h2;
  localparam [3:0] ST_REF = 4'h3;
  localparam [3:0] ST_REFW = 4'h4;
  localparam [3:0] ST_MODE = 4'h5;
  localparam [3:0] ST_MODEW = 4'h6;
  localparam [3:0] ST_IDLE = 4'h7;
  localparam [3:0] ST_ACT = 4'h8;
  localparam [3:0] ST_ACTW = 4'h9;
  localparam [3:0] ST_PRECH = 4'ha;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0] ctrl_q;
  reg [7:0] geom_q;
  reg [7:0] ref_lo_q;
  reg [7:0] ref_hi_q;
  reg [7:0] init_lo_q;
  reg [7:0] init_hi_q;
  reg [7:0] timing_q;
  reg [31:0] rdata_d;
  reg mapped;

  // ----------------------------------------
  // Register fields
  // ----------------------------------------
  wire [1:0] port_count_sel = ctrl_q[`FLD_PORT_COUNT];
  wire [1:0] static_ram_mux_sel = ctrl_q[`FLD_STATIC_MUX];
  wire [1:0] low_pin_mux_sel = ctrl_q[`FLD_LOW_PIN_MUX];
  wire [1:0] sdram_bus_width_sel = ctrl_q[`FLD_BUS_WIDTH];
  wire column_latency_sel = geom_q[`FLD_COL_LATENCY];
  wire row_width_sel = geom_q[`FLD_ROW_WIDTH];
  wire [1:0] column_width_sel = geom_q[`FLD_COL_WIDTH];
  wire [9:0] refresh_period = {ref_hi_q[`FLD_REF_HI], ref_lo_q};
  wire [13:0] powerup_wait_count = {init_hi_q[`FLD_INIT_HI], init_lo_q};
  wire [1:0] mode_load_to_activate_wait = timing_q[`FLD_MODE_WAIT];
  wire [2:0] refresh_to_activate_wait = timing_q[`FLD_REF_WAIT];
  wire [2:0] activate_to_precharge_wait = timing_q[`FLD_ACT_WAIT];

  // ----------------------------------------
  // Register access
  // ----------------------------------------
  wire [5:0] reg_idx = paddr[7:2];
  wire setup = psel & ~penable;
  wire wr_en = psel & penable & pwrite & mapped;

  // Zero wait states: every access phase completes at once
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  always @* begin
    mapped = 1'b1;
    rdata_d = 32'h00000000;
    case (reg_idx)
      {2'h0, `IDX_CTRL}: rdata_d[7:0] = ctrl_q;
      {2'h0, `IDX_GEOM}: rdata_d[7:0] = geom_q;
      {2'h0, `IDX_REF_LO}: rdata_d[7:0] = ref_lo_q;
      {2'h0, `IDX_REF_HI}: rdata_d[7:0] = ref_hi_q;
      {2'h0, `IDX_INIT_LO}: rdata_d[7:0] = init_lo_q;
      {2'h0, `IDX_INIT_HI}: rdata_d[7:0] = init_hi_q;
      {2'h0, `IDX_TIMING}: rdata_d[7:0] = timing_q;
      default: mapped = 1'b0;
    endcase
    // A misaligned access is refused and reads back zero
    if (paddr[1:0] != 2'h0) begin
      mapped = 1'b0;
      rdata_d = 32'h00000000; // R18
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= `REG_RESET;
      geom_q <= `REG_RESET;
      ref_lo_q <= `REG_RESET;
      ref_hi_q <= `REG_RESET;
      init_lo_q <= `REG_RESET;
      init_hi_q <= `REG_RESET;
      timing_q <= `REG_RESET;
      prdata <= 32'h00000000;
    end else begin
      // Caught in setup so it stands through the whole access phase
      if (setup) begin
        prdata <= rdata_d;
      end
      if (wr_en) begin
        case (reg_idx[3:0])
          `IDX_CTRL: ctrl_q <= pwdata[7:0];
          `IDX_GEOM: geom_q <= pwdata[7:0] & `GEOM_MASK; // R18
          `IDX_REF_LO: ref_lo_q <= pwdata[7:0];
          `IDX_REF_HI: ref_hi_q <= pwdata[7:0] & `REF_HI_MASK; // R18
          `IDX_INIT_LO: init_lo_q <= pwdata[7:0];
          `IDX_INIT_HI: init_hi_q <= pwdata[7:0] & `INIT_HI_MASK; // R18
          `IDX_TIMING: timing_q <= pwdata[7:0];
          default: ctrl_q <= ctrl_q;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Effective configuration
  // ----------------------------------------
  wire bus_on = (port_count_sel != `PORTS_OFF);
  wire four_port = (port_count_sel == `PORTS_FOUR);

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      port_enable <= 4'h0;
      data_dir_override <= 1'b0;
      data_val_override <= 1'b0;
      addr_val_override <= 1'b0;
      data_width_eight <= 1'b0;
      low_pin_mux_mode <= `LOW_PIN_FIRST;
      static_ram_mux_mode <= `SRAM_FIRST;
      cas_latency <= `CAS_SHORT;
      row_bits <= `ROW_SHORT;
      col_bits <= `COL_BASE;
    end else begin
      case (port_count_sel) // R6
        `PORTS_THREE: port_enable <= 4'h7;
        `PORTS_FOUR: port_enable <= 4'hf;
        `PORTS_TWO: port_enable <= 4'h3;
        default: port_enable <= 4'h0;
      endcase
      data_dir_override <= bus_on; // R17
      data_val_override <= bus_on; // R17
      addr_val_override <= bus_on; // R17
      // Unsupported or reserved settings keep the previous setting, except width outside four-port mode
      if (sdram_bus_width_sel == `WIDTH_FOUR) begin
        data_width_eight <= 1'b0; // R1
      end else if (sdram_bus_width_sel == `WIDTH_EIGHT && four_port) begin
        data_width_eight <= 1'b1; // R1 R2
        // Eight-bit width falls back to four bits outside four-port mode
      end else if (!four_port) begin
        data_width_eight <= 1'b0; // R2
      end
      if (low_pin_mux_sel == `LOW_PIN_FIRST || low_pin_mux_sel == `LOW_PIN_BOTH) begin
        low_pin_mux_mode <= low_pin_mux_sel; // R3 R18
      end
      if (static_ram_mux_sel == `SRAM_FIRST || static_ram_mux_sel == `SRAM_BOTH) begin
        static_ram_mux_mode <= static_ram_mux_sel; // R4
      end else if (four_port) begin
        static_ram_mux_mode <= static_ram_mux_sel; // R4 R5
      end
      cas_latency <= column_latency_sel ? `CAS_LONG : `CAS_SHORT; // R7
      row_bits <= row_width_sel ? `ROW_LONG : `ROW_SHORT; // R8
      col_bits <= `COL_BASE + {2'h0, column_width_sel}; // R9
    end
  end

  // ----------------------------------------
  // Fast peripheral clock edge detection
  // ----------------------------------------
  reg per_s1_q;
  reg per_s2_q;
  reg per_s3_q;
  // Two stages tame the asynchronous pin; the third finds its rising edge
  wire tick = per_s2_q & ~per_s3_q;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      per_s1_q <= 1'b0;
      per_s2_q <= 1'b0;
      per_s3_q <= 1'b0;
    end else begin
      per_s1_q <= fast_peripheral_clock;
      per_s2_q <= per_s1_q;
      per_s3_q <= per_s2_q;
    end
  end

  // ----------------------------------------
  // Refresh timer and pending queue
  // ----------------------------------------
  reg [9:0] ref_cnt_q;
  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [13:0] wait_q;
  reg [13:0] wait_d;
  reg [2:0] cmd_d;
  // Period zero switches automatic refresh off
  wire ref_due = tick & (refresh_period != 10'h000) & (ref_cnt_q + 10'h001 >= refresh_period);
  wire ref_issue = (state_q == ST_IDLE) & (refresh_pending != 3'h0) & ~ext_busy;
  // Runs once init is done, so refresh states do not flush the queue
  wire ref_count = sdram_ready;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ref_cnt_q <= 10'h000;
      refresh_pending <= 3'h0;
    end else if (!ref_count) begin
      ref_cnt_q <= 10'h000;
      refresh_pending <= 3'h0;
    end else begin
      if (ref_due) begin
        ref_cnt_q <= 10'h000; // R10
      end else if (tick) begin
        ref_cnt_q <= ref_cnt_q + 10'h001; // R10
      end
      // A due and an issued refresh in one cycle cancel out
      if (ref_due && !ref_issue && refresh_pending != REFRESH_QUEUE_DEPTH) begin
        refresh_pending <= refresh_pending + 3'h1; // R11
      end else if (!ref_due && ref_issue) begin
        refresh_pending <= refresh_pending - 3'h1; // R11
      end
    end
  end

  // ----------------------------------------
  // SDRAM sequencer
  // ----------------------------------------
  // One counter serves every programmed wait and steps down per tick
  wire wait_done = (wait_q == 14'h0000);
  // A pending refresh goes before a row open while ext_busy is low
  assign act_ack = (state_q == ST_IDLE) & act_req & ~ref_issue;

  always @* begin
    state_d = state_q;
    wait_d = wait_q;
    cmd_d = `CMD_NOP;
    if (tick && !wait_done) begin
      wait_d = wait_q - 14'h0001;
    end
    case (state_q)
      ST_OFF: begin
        // Reload the power-up wait until the bus is switched on
        wait_d = powerup_wait_count; // R12
        state_d = ST_PWR;
      end
      ST_PWR: begin
        if (wait_done) begin
          state_d = ST_PRE; // R12
        end
      end
      ST_PRE: begin
        cmd_d = `CMD_PRECHARGE; // R13
        state_d = ST_REF;
      end
      ST_REF: begin
        cmd_d = `CMD_REFRESH; // R13
        wait_d = {11'h000, refresh_to_activate_wait}; // R15
        state_d = ST_REFW;
      end
      ST_REFW: begin
        if (wait_done) begin
          // One refresh path serves init and every later refresh
          state_d = sdram_ready ? ST_IDLE : ST_MODE; // R15
        end
      end
      ST_MODE: begin
        cmd_d = `CMD_LOAD_MODE; // R13
        wait_d = {12'h000, mode_load_to_activate_wait}; // R14
        state_d = ST_MODEW;
      end
      ST_MODEW: begin
        if (wait_done) begin
          state_d = ST_IDLE; // R14
        end
      end
      ST_IDLE: begin
        if (ref_issue) begin
          state_d = ST_REF; // R11
        end else if (act_req) begin
          state_d = ST_ACT;
        end
      end
      ST_ACT: begin
        cmd_d = `CMD_ACTIVE;
        wait_d = {11'h000, activate_to_precharge_wait}; // R16
        state_d = ST_ACTW;
      end
      ST_ACTW: begin
        if (wait_done) begin
          state_d = ST_PRECH; // R16
        end
      end
      ST_PRECH: begin
        cmd_d = `CMD_PRECHARGE;
        state_d = ST_IDLE;
      end
      default: state_d = ST_OFF;
    endcase
    // Turning the bus off restarts the whole init sequence
    if (!bus_on) begin
      state_d = ST_OFF;
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_OFF;
      wait_q <= 14'h0000;
      sdram_cmd <= `CMD_NOP;
      sdram_ready <= 1'b0;
    end else begin
      state_q <= state_d;
      wait_q <= wait_d;
      // No command leaves the block while the bus is off
      sdram_cmd <= bus_on ? cmd_d : `CMD_NOP;
      if (!bus_on) begin
        sdram_ready <= 1'b0;
      end else if (state_q == ST_MODEW && wait_done) begin
        sdram_ready <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ---- ext_bus_sdram_config_monitor.sv ----
// Port-level checks for the external bus configuration block
`timescale 1ns/1ps
`default_nettype none
`include "ext_bus_sdram_config_regs.vh"
module ext_bus_sdram_config_monitor (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic act_req,
  input wire logic act_ack,
  input wire logic [2:0] sdram_cmd,
  input wire logic sdram_ready,
  input wire logic [3:0] port_enable,
  input wire logic data_dir_override,
  input wire logic [1:0] cas_latency,
  input wire logic [3:0] row_bits,
  input wire logic [3:0] col_bits,
  input wire logic [2:0] refresh_pending
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire acc = psel && penable;
  wire wr = acc && pwrite && pready;
  wire bad = paddr[1:0] != 2'h0 || paddr[7:2] inside {[2:3], [9:63]};
  function automatic logic [3:0] pe_of(logic [1:0] m);
    return m == 2'h0 ? 4'h0 : m == 2'h1 ? 4'h7 : m == 2'h2 ? 4'hf : 4'h3;
  endfunction
  sequence init_pre;
    sdram_cmd == `CMD_PRECHARGE && !sdram_ready;
  endsequence
  sequence init_ref;
    sdram_cmd == `CMD_REFRESH;
  endsequence
  bad_addr_a: assert property (acc && bad |-> pslverr)
    else $error("no slave error");
  cas_latency_a: assert property (wr && paddr == 8'h04 |-> ##2
    cas_latency == {1'b1, $past(pwdata[3], 2)}) else $error("latency wrong");
  row_width_a: assert property (wr && paddr == 8'h04 |-> ##2
    row_bits == 4'hb + $past(pwdata[2], 2)) else $error("row width wrong");
  col_width_a: assert property (wr && paddr == 8'h04 |-> ##2
    col_bits == 4'h8 + $past(pwdata[1:0], 2)) else $error("column width wrong");
  port_sel_a: assert property (wr && paddr == 8'h00 |-> ##2
    port_enable == pe_of($past(pwdata[1:0], 2))) else $error("port enable wrong");
  pin_override_a: assert property (data_dir_override == (port_enable != 4'h0))
    else $error("override wrong");
  ack_ready_a: assert property (act_ack |-> act_req && sdram_ready)
    else $error("early activate");
  ack_active_a: assert property (act_ack |-> ##[1:2] sdram_cmd == `CMD_ACTIVE)
    else $error("no activate");
  init_order_a: assert property (init_pre |=> init_ref)
    else $error("init order wrong");
  mode_ready_a: assert property (sdram_cmd == `CMD_LOAD_MODE && !sdram_ready
    |-> ##[1:60] sdram_ready) else $error("ready late");
  pend_max_a: assert property (refresh_pending <= 3'h4)
    else $error("pending over four");
endmodule
bind ext_bus_sdram_config ext_bus_sdram_config_monitor i_mon (
  .core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .act_req, .act_ack, .sdram_cmd, .sdram_ready, .port_enable, .data_dir_override,
  .cas_latency, .row_bits, .col_bits, .refresh_pending
);
`default_nettype wire

// ---- far_mem_model.sv ----
// Far-side memory user: asks for row opens and holds the bus busy
`timescale 1ns/1ps
`default_nettype none
module far_mem_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic open_go,
  input wire logic stall,
  input wire logic act_ack,
  output logic act_req,
  output logic ext_busy
);
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      act_req <= 1'b0;
      ext_busy <= 1'b0;
    end else begin
      ext_busy <= stall;
      if (act_ack)
        act_req <= 1'b0;
      else if (open_go)
        act_req <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Testbench for the external bus configuration block
`timescale 1ns/1ps
`default_nettype none
`include "ext_bus_sdram_config_regs.vh"
module tb_top;
  logic core_clk, rst, psel, penable, pwrite, fast_peripheral_clock, open_go, stall;
  logic [7:0] paddr;
  logic [31:0] pwdata, r;
  wire pready, pslverr, act_ack, act_req, ext_busy, sdram_ready, data_width_eight;
  wire data_dir_override, data_val_override, addr_val_override;
  wire [31:0] prdata;
  wire [2:0] sdram_cmd, refresh_pending;
  wire [3:0] port_enable, row_bits, col_bits;
  wire [1:0] low_pin_mux_mode, static_ram_mux_mode, cas_latency;
  int fail_count, cmp_count;
  realtime t_ref;
  logic [32:0] rd_q[$];
  logic [2:0] cmd_q[$];
  logic [7:0] ad[7] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
  logic [7:0] mk[7] = '{8'hff, 8'h0f, 8'hff, 8'h03, 8'hff, 8'h3f, 8'hff};
  logic [7:0] ct[5] = '{8'h6a, 8'h55, 8'h0e, 8'hb3, 8'h00};
  logic [8:0] ex[5] = '{9'h1fa, 9'h0ea, 9'h1e3, 9'h060, 9'h000};
  ext_bus_sdram_config i_ext_bus_sdram_config (
    .core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .fast_peripheral_clock, .ext_busy, .act_req, .act_ack, .sdram_cmd,
    .sdram_ready, .port_enable, .data_dir_override, .data_val_override,
    .addr_val_override, .data_width_eight, .low_pin_mux_mode, .static_ram_mux_mode,
    .cas_latency, .row_bits, .col_bits, .refresh_pending
  );
  far_mem_model i_far_mem_model (
    .core_clk, .rst, .open_go, .stall, .act_ack, .act_req, .ext_busy
  );
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    fast_peripheral_clock = 1'b0;
    #3;
    forever #62.5 fast_peripheral_clock = ~fast_peripheral_clock;
  end
  task automatic chk(string n, logic [32:0] e, logic [32:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [32:0] e);
    rd_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic settle;
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------
  // Result watcher
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (psel && penable && pready && !pwrite)
      chk("read", rd_q.pop_front(), {pslverr, prdata});
    if (!rst && sdram_cmd !== `CMD_NOP) begin
      if (sdram_cmd == `CMD_PRECHARGE)
        chk("wait", 1, $realtime - t_ref >= 250 && $realtime - t_ref <= 430);
      if (sdram_cmd == `CMD_ACTIVE)
        t_ref = $realtime;
      chk("cmd", cmd_q.size() ? cmd_q.pop_front() : 3'h7, sdram_cmd);
    end
  end
  initial begin
    #100000;
    fail_count++;
    wrap_up;
  end
  initial begin
    {rst, psel, penable, pwrite, open_go, stall} = 6'h20;
    paddr = 8'h00;
    pwdata = 32'h0;
    fail_count = 0;
    cmp_count = 0;
    r = $urandom(51);
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    chk("cas", 2, cas_latency);
    chk("row", 11, row_bits);
    chk("col", 8, col_bits);
    rd(8'h0c, 33'h1_0000_0000);
    rd(8'h05, 33'h1_0000_0000);
    for (int i = 0; i < 7; i++) begin
      r = $urandom & (i ? 32'hffff_ffff : 32'hffff_fffc);
      rd(ad[i], 33'h0);
      apb(1'b1, ad[i], r);
      rd(ad[i], r[7:0] & mk[i]);
    end
    for (int g = 0; g < 16; g++) begin
      apb(1'b1, 8'h04, g);
      settle;
      chk("cas", 2 + g[3], cas_latency);
      chk("row", 11 + g[2], row_bits);
      chk("col", 8 + g[1:0], col_bits);
    end
    rd(8'h05, 33'h1_0000_0000);
    apb(1'b1, 8'h18, 8'hff);
    apb(1'b1, 8'h1c, 8'h3f);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, 8'h00, ct[i]);
      settle;
      chk("mode", ex[i], {port_enable, data_width_eight, low_pin_mux_mode,
        static_ram_mux_mode});
      chk("ovr", {3{ex[i][8:5] != 4'h0}},
        {data_dir_override, data_val_override, addr_val_override});
    end
    apb(1'b1, 8'h20, 8'h53);
    apb(1'b1, 8'h10, 8'h00);
    apb(1'b1, 8'h14, 8'h00);
    apb(1'b1, 8'h18, 8'h03);
    apb(1'b1, 8'h1c, 8'h00);
    cmd_q = '{`CMD_PRECHARGE, `CMD_REFRESH, `CMD_LOAD_MODE};
    apb(1'b1, 8'h00, 8'h02);
    t_ref = $realtime;
    wait (sdram_ready === 1'b1);
    cmd_q = '{`CMD_ACTIVE, `CMD_PRECHARGE};
    open_go <= 1'b1;
    @(posedge core_clk);
    open_go <= 1'b0;
    repeat (200) @(posedge core_clk);
    chk("left", 0, cmd_q.size());
    stall <= 1'b1;
    apb(1'b1, 8'h10, 8'h04);
    repeat (400) @(posedge core_clk);
    chk("pend", 4, refresh_pending);
    apb(1'b1, 8'h10, 8'h00);
    cmd_q = '{4{`CMD_REFRESH}};
    stall <= 1'b0;
    repeat (300) @(posedge core_clk);
    chk("pend", 0, refresh_pending);
    chk("left", 0, cmd_q.size());
    wrap_up;
  end
endmodule
`default_nettype wire
